// >>> rtl/ccm_regs.vh
// Register offsets, fields, mode codes and reset values of the mode control block
`ifndef CCM_REGS_VH
`define CCM_REGS_VH
// Byte addresses of the word registers
`define CCM_ADDR_CTRL 4'h0
`define CCM_ADDR_DUTY 4'h4
`define CCM_ADDR_PER 4'h8
`define CCM_ADDR_STAT 4'hC
// Mode control register fields
`define CCM_MODE_HI 3
`define CCM_MODE_LO 0
`define CCM_DUTY_HI 5
`define CCM_DUTY_LO 4
`define CCM_CTRL_MASK 8'h3F
// Mode codes
`define CCM_M_OFF 4'h0
`define CCM_M_TOGGLE 4'h2
`define CCM_M_CAP_FALL 4'h4
`define CCM_M_CAP_RISE 4'h5
`define CCM_M_CAP_4 4'h6
`define CCM_M_CAP_16 4'h7
`define CCM_M_CMP_SET 4'h8
`define CCM_M_CMP_CLR 4'h9
`define CCM_M_CMP_IRQ 4'hA
`define CCM_M_CMP_TRIG 4'hB
`define CCM_PWM_TOP 2'h3
// Prescaled capture thresholds, counter value that fires
`define CCM_PRE4_LAST 4'h3
`define CCM_PRE16_LAST 4'hF
// Status and mask bit positions
`define CCM_ST_EVENT 0
`define CCM_ST_PERIOD 1
// Reset values
`define CCM_CTRL_RST 8'h00
`define CCM_BYTE_RST 8'h00
`define CCM_ST_RST 2'h0
`endif

// >>> rtl/ccm_edge_prescaler.v
// Pin edge detector with capture prescaler
`timescale 1ns/100ps
`include "ccm_regs.vh"
module ccm_edge_prescaler (
   // Clock and reset
   input wire ref_clk,
   input wire rst_n,
   // Control
   input wire [3:0] mode,
   // Pin sample
   input wire pin_in,
   // Capture strobe, one cycle
   output reg capture
);
   reg pin_d_reg;    // Previous pin level
   reg [3:0] cnt_reg; // Rising edge count
   wire rise = pin_in & ~pin_d_reg;
   wire fall = ~pin_in & pin_d_reg;

   // Edge history and prescale count
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_d_reg <= 1'b0;
         cnt_reg <= 4'h0;
         capture <= 1'b0;
      end else begin
         pin_d_reg <= pin_in;
         capture <= 1'b0;
         case (mode)
            `CCM_M_CAP_FALL: begin
               capture <= fall;
               cnt_reg <= 4'h0;
            end
            `CCM_M_CAP_RISE: begin
               capture <= rise;
               cnt_reg <= 4'h0;
            end
            `CCM_M_CAP_4: begin
               if (rise) begin
                  capture <= (cnt_reg[1:0] == `CCM_PRE4_LAST);
                  cnt_reg <= (cnt_reg[1:0] == `CCM_PRE4_LAST) ? 4'h0 : cnt_reg + 4'h1;
               end
            end
            `CCM_M_CAP_16: begin
               if (rise) begin
                  capture <= (cnt_reg == `CCM_PRE16_LAST);
                  cnt_reg <= cnt_reg + 4'h1;
               end
            end
            // Prescaler cleared outside capture
            default: begin
               cnt_reg <= 4'h0;
            end
         endcase
      end
   end
endmodule

// >>> rtl/ccm_mode_control.v
// Capture/compare/PWM mode control with Wishbone registers
//
// Chosen here: the address map and the Wishbone slave port.
`timescale 1ns/100ps
`include "ccm_regs.vh"
module ccm_mode_control (
   // Clock and reset
   input wire ref_clk,
   input wire rst_n,
   // Wishbone slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [3:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   // Unit pin
   input wire unit_pin_in,
   output reg unit_pin_out,
   output reg unit_pin_oe,
   // Compare match from the timer data path
   input wire compare_match,
   // Side effects
   output reg timer_reset,
   output reg adc_start,
   input wire adc_enabled,
   output reg capture_strobe,
   // Interrupt
   output reg irq
);
   reg [7:0] mode_control_reg; // Low six bits used
   reg [7:0] duty_high_byte_reg;   // Software duty high byte
   reg [7:0] period_limit_reg;     // Period limit
   reg [9:0] duty_active_buffer_reg; // Latched duty
   reg [7:0] period_timer_reg;     // PWM period timer
   reg [1:0] sub_cnt_reg;          // Two system clock bits
   reg [1:0] status_reg;           // Sticky events
   reg [1:0] mask_reg;             // Interrupt enables
   reg [3:0] mode_prev_reg;        // Mode last cycle
   wire [3:0] unit_mode_select = mode_control_reg[`CCM_MODE_HI:`CCM_MODE_LO];
   wire [1:0] duty_low_bits = mode_control_reg[`CCM_DUTY_HI:`CCM_DUTY_LO];
   wire pwm_mode = (unit_mode_select[3:2] == `CCM_PWM_TOP);
   wire mode_change = (unit_mode_select != mode_prev_reg);
   wire cap_evt;
   wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire wb_wr = wb_req & wb_we_i;
   wire [9:0] time_base = {period_timer_reg, sub_cnt_reg};
   // Time base value of the coming cycle; clearing on it keeps the pulse at duty clocks
   wire [9:0] time_base_next = time_base + 10'h001;
   wire period_end = pwm_mode & (period_timer_reg == period_limit_reg)
                     & (sub_cnt_reg == 2'h3);
   wire cmp_mode = (unit_mode_select == `CCM_M_TOGGLE) | (unit_mode_select[3:2] == 2'h2);
   wire cmp_evt = cmp_mode & compare_match & ~mode_change;
   reg [1:0] st_set;

   // Edge detector and capture prescaler
   ccm_edge_prescaler u_pre (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .mode(unit_mode_select),
      .pin_in(unit_pin_in),
      .capture(cap_evt)
   );

   // Event sources for the sticky status
   always @* begin
      st_set = 2'h0;
      st_set[`CCM_ST_EVENT] = cap_evt | cmp_evt;
      st_set[`CCM_ST_PERIOD] = period_end;
   end

   // Wishbone write path and status; set beats write-one-clear
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_control_reg <= `CCM_CTRL_RST;
         duty_high_byte_reg <= `CCM_BYTE_RST;
         period_limit_reg <= `CCM_BYTE_RST;
         status_reg <= `CCM_ST_RST;
         mask_reg <= `CCM_ST_RST;
      end else begin
         if (wb_wr && wb_sel_i[0]) begin
            case (wb_adr_i)
               `CCM_ADDR_CTRL: mode_control_reg <= wb_dat_i[7:0] & `CCM_CTRL_MASK;
               `CCM_ADDR_DUTY: duty_high_byte_reg <= wb_dat_i[7:0];
               `CCM_ADDR_PER: period_limit_reg <= wb_dat_i[7:0];
               default: begin
               end
            endcase
         end
         // Upper word half holds the mask
         if (wb_wr && wb_sel_i[2] && wb_adr_i == `CCM_ADDR_STAT)
            mask_reg <= wb_dat_i[17:16];
         // Clear by write of one, new events win
         if (wb_wr && wb_sel_i[0] && wb_adr_i == `CCM_ADDR_STAT)
            status_reg <= (status_reg & ~wb_dat_i[1:0]) | st_set;
         else
            status_reg <= status_reg | st_set;
      end
   end

   // Wishbone read and ack, one cycle after request
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_req;
         if (wb_req && !wb_we_i) begin
            case (wb_adr_i)
               `CCM_ADDR_CTRL: wb_dat_o <= {24'h00_0000, mode_control_reg};
               `CCM_ADDR_DUTY: wb_dat_o <= {14'h0000, duty_active_buffer_reg,
                                           duty_high_byte_reg};
               `CCM_ADDR_PER: wb_dat_o <= {16'h0000, period_timer_reg, period_limit_reg};
               `CCM_ADDR_STAT: wb_dat_o <= {14'h0000, mask_reg, 14'h0000, status_reg};
               default: wb_dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Interrupt level from masked status
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
         irq <= 1'b0;
      else
         irq <= |((status_reg | st_set) & mask_reg);
   end

   // PWM time base and duty double buffer
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         period_timer_reg <= `CCM_BYTE_RST;
         sub_cnt_reg <= 2'h0;
         duty_active_buffer_reg <= 10'h000;
      end else if (!pwm_mode) begin
         period_timer_reg <= `CCM_BYTE_RST;
         sub_cnt_reg <= 2'h0;
      end else begin
         // time base is timer plus two clock bits
         sub_cnt_reg <= sub_cnt_reg + 2'h1;
         if (period_end) begin
            period_timer_reg <= `CCM_BYTE_RST;
            // duty latched only at period end
            duty_active_buffer_reg <= {duty_high_byte_reg, duty_low_bits};
         end else if (sub_cnt_reg == 2'h3) begin
            period_timer_reg <= period_timer_reg + 8'h01;
         end
      end
   end

   // Pin drive, strobes and mode tracking
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         unit_pin_out <= 1'b0;
         unit_pin_oe <= 1'b0;
         timer_reset <= 1'b0;
         adc_start <= 1'b0;
         capture_strobe <= 1'b0;
         mode_prev_reg <= `CCM_M_OFF;
      end else begin
         mode_prev_reg <= unit_mode_select;
         timer_reset <= 1'b0;
         adc_start <= 1'b0;
         capture_strobe <= cap_evt;
         if (pwm_mode) begin
            unit_pin_oe <= 1'b1;
            if (period_end)
               // set pin unless duty is zero
               unit_pin_out <= ({duty_high_byte_reg, duty_low_bits} != 10'h000);
            else if (time_base_next == duty_active_buffer_reg)
               unit_pin_out <= 1'b0;
         end else begin
            case (unit_mode_select)
               `CCM_M_CMP_SET: begin
                  unit_pin_oe <= 1'b1;
                  // low on select, high on match
                  if (mode_change)
                     unit_pin_out <= 1'b0;
                  else if (cmp_evt)
                     unit_pin_out <= 1'b1;
               end
               `CCM_M_CMP_CLR: begin
                  unit_pin_oe <= 1'b1;
                  // high on select, low on match
                  if (mode_change)
                     unit_pin_out <= 1'b1;
                  else if (cmp_evt)
                     unit_pin_out <= 1'b0;
               end
               `CCM_M_TOGGLE: begin
                  unit_pin_oe <= 1'b1;
                  if (cmp_evt)
                     unit_pin_out <= ~unit_pin_out;
               end
               `CCM_M_CMP_TRIG: begin
                  unit_pin_oe <= 1'b0;
                  timer_reset <= cmp_evt;
                  adc_start <= cmp_evt & adc_enabled;
               end
               default: begin
                  unit_pin_oe <= 1'b0;
                  unit_pin_out <= 1'b0;
               end
            endcase
         end
      end
   end
endmodule

// >>> test/ccm_mode_control_checker.sv
// Port-level assertion checker for the mode control block
`timescale 1ns/100ps
module ccm_mode_control_checker (
   // Clock and reset
   input wire ref_clk,
   input wire rst_n,
   // Bus request
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [3:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   input wire wb_ack_o,
   // Pin and events
   input wire unit_pin_in,
   input wire unit_pin_out,
   input wire unit_pin_oe,
   input wire compare_match,
   input wire timer_reset,
   input wire adc_start,
   input wire adc_enabled,
   input wire capture_strobe
);
   // Shadow mode field and edges since it was written
   logic [3:0] m_reg;
   logic [1:0] age_reg;
   // Settled, so the ignored first match cycle is skipped
   wire ok = age_reg == 2'h3;
   // Track control writes at the taking edge
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         m_reg <= 4'h0;
         age_reg <= 2'h3;
      end else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == 4'h0
         && wb_sel_i[0]) begin
         m_reg <= wb_dat_i[3:0];
         age_reg <= 2'h0;
      end else if (!ok) begin
         age_reg <= age_reg + 2'h1;
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // A match seen in a settled mode
   sequence s_hit(logic [3:0] c);
      compare_match && m_reg == c && ok;
   endsequence
   a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing after request");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_cap_fall: assert property ($fell(unit_pin_in) && m_reg == 4'h4 && ok |-> ##[1:2] capture_strobe)
      else $error("no capture on falling edge");
   a_cap_rise: assert property ($rose(unit_pin_in) && m_reg == 4'h5 && ok |-> ##[1:2] capture_strobe)
      else $error("no capture on rising edge");
   a_set_on_match: assert property (s_hit(4'h8) |=> unit_pin_oe && unit_pin_out)
      else $error("pin not set on match");
   a_clr_on_match: assert property (s_hit(4'h9) |=> unit_pin_oe && !unit_pin_out)
      else $error("pin not cleared on match");
   a_toggle_match: assert property (s_hit(4'h2) |=> unit_pin_out != $past(unit_pin_out))
      else $error("pin not toggled on match");
   a_trig_match: assert property (s_hit(4'hB) |=> timer_reset && adc_start == $past(adc_enabled))
      else $error("trigger side effects wrong");
   a_irq_only_free: assert property (m_reg == 4'hA && ok |-> !unit_pin_oe)
      else $error("pin driven in flag-only mode");
   a_off_quiet: assert property (m_reg == 4'h0 && ok |-> !unit_pin_oe && !timer_reset)
      else $error("unit active while off");
endmodule
bind ccm_mode_control ccm_mode_control_checker u_chk (.ref_clk, .rst_n, .wb_cyc_i, .wb_stb_i,
   .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .unit_pin_in, .unit_pin_out,
   .unit_pin_oe, .compare_match, .timer_reset, .adc_start, .adc_enabled, .capture_strobe);

// >>> test/ccm_pin_load.sv
// Outside circuit that shares the unit pin
`timescale 1ns/100ps
module ccm_pin_load (
   // Device drive
   input wire pin_out,
   input wire pin_oe,
   // Outside drive while released
   input wire ext_level,
   // Wire level
   output wire pin_level
);
   // Device wins while enabled, else the outside level shows
   assign pin_level = pin_oe ? pin_out : ext_level;
endmodule

// >>> test/ccm_mode_control_tb_top.sv
// Self-checking bench for the mode control block
`timescale 1ns/100ps
module ccm_mode_control_tb_top;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic cyc, stb, we, match, adc_en, ext;
   logic [3:0] adr, sel;
   logic [31:0] dat, rdat;
   wire [31:0] dat_o;
   wire ack, pin_out, pin_oe, pin, trst, adc_go, cap, irq;
   integer mismatches = 0;
   integer n_checks = 0;
   integer cap_cnt = 0;
   ccm_mode_control u_ccm_mode_control (.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
      .wb_dat_o(dat_o), .wb_ack_o(ack), .unit_pin_in(pin), .unit_pin_out(pin_out),
      .unit_pin_oe(pin_oe), .compare_match(match), .timer_reset(trst), .adc_start(adc_go),
      .adc_enabled(adc_en), .capture_strobe(cap), .irq(irq));
   ccm_pin_load u_ccm_pin_load (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext),
      .pin_level(pin));
   initial forever #2 ref_clk = ~ref_clk;
   // Count capture pulses
   always @(posedge ref_clk) if (cap === 1'b1) cap_cnt <= cap_cnt + 1;
   task wrap_up;
      if (mismatches == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task chk(input [31:0] seen, input [31:0] exp);
      n_checks = n_checks + 1;
      if (seen !== exp) begin
         mismatches = mismatches + 1;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One classic cycle, bounded wait for ack, one idle cycle after
   task wb(input [3:0] a, input [31:0] d, input [3:0] s, input w);
      integer i;
      begin
         {cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, s, d};
         i = 0;
         do begin
            @(posedge ref_clk);
            i = i + 1;
         end while (ack !== 1'b1 && i < 20);
         if (ack !== 1'b1) begin
            mismatches = mismatches + 1;
            wrap_up;
         end
         rdat = dat_o;
         {cyc, stb} <= 2'b00;
         @(posedge ref_clk);
      end
   endtask
   task t_regs;
      begin
         wb(4'h0, 32'h0, 4'h1, 1'b0);
         chk(rdat, 32'h0);
         wb(4'h0, 32'hFF, 4'h1, 1'b1);
         wb(4'h0, 32'h0, 4'h1, 1'b0);
         chk(rdat, 32'h3F);
         wb(4'h2, 32'hFF, 4'h1, 1'b1);
         wb(4'h2, 32'h0, 4'h1, 1'b0);
         chk(rdat, 32'h0);
         // Back to off so a driven pin level cannot fake a capture edge later
         wb(4'h0, 32'h0, 4'h1, 1'b1);
         repeat (3) @(posedge ref_clk);
      end
   endtask
   // Sixteen pin pulses in each capture mode
   task t_capture;
      integer k, j, c0;
      for (k = 0; k < 4; k++) begin
         wb(4'h0, 32'h4 + k, 4'h1, 1'b1);
         c0 = cap_cnt;
         for (j = 0; j < 16; j++) begin
            ext <= 1'b1;
            repeat (3) @(posedge ref_clk);
            ext <= 1'b0;
            repeat (3) @(posedge ref_clk);
         end
         repeat (4) @(posedge ref_clk);
         chk(cap_cnt - c0, k < 2 ? 16 : (k == 2 ? 4 : 1));
      end
   endtask
   // One match in each compare mode, flag set then cleared
   task t_compare;
      integer k;
      logic [3:0] m;
      logic pre;
      for (k = 0; k < 5; k++) begin
         m = k == 4 ? 4'h2 : 4'h8 + k[3:0];
         wb(4'h0, {28'h0, m}, 4'h1, 1'b1);
         repeat (3) @(posedge ref_clk);
         #1 chk(pin_oe, m != 4'hA && m != 4'hB);
         if (m[3:1] == 3'h4) chk(pin_out, m[0]);
         pre = pin_out;
         @(posedge ref_clk);
         match <= 1'b1;
         @(posedge ref_clk);
         match <= 1'b0;
         #1 chk(trst, m == 4'hB);
         chk(adc_go, m == 4'hB);
         if (m != 4'hA && m != 4'hB) chk(pin_out, m == 4'h8 ? 1'b1 : (m == 4'h9 ? 1'b0 : !pre));
         @(posedge ref_clk);
         wb(4'hC, 32'h0, 4'h1, 1'b0);
         chk(rdat[0], 1'b1);
         wb(4'hC, 32'h1, 4'h1, 1'b1);
         wb(4'hC, 32'h0, 4'h1, 1'b0);
         chk(rdat[0], 1'b0);
      end
   endtask
   // Masked flag keeps irq low until the mask opens
   task t_irq;
      begin
         wb(4'h0, 32'h8, 4'h1, 1'b1);
         repeat (3) @(posedge ref_clk);
         match <= 1'b1;
         @(posedge ref_clk);
         match <= 1'b0;
         repeat (2) @(posedge ref_clk);
         #1 chk(irq, 1'b0);
         @(posedge ref_clk);
         wb(4'hC, 32'h1_0000, 4'h4, 1'b1);
         #1 chk(irq, 1'b1);
         @(posedge ref_clk);
         wb(4'hC, 32'h1, 4'h1, 1'b1);
         #1 chk(irq, 1'b0);
         @(posedge ref_clk);
      end
   endtask
   // Period of 16 clocks; any 16-cycle window holds the duty count
   task t_pwm;
      integer k, j, h;
      logic [7:0] c;
      begin
         wb(4'h8, 32'h3, 4'h1, 1'b1);
         for (k = 0; k < 3; k++) begin
            c = k == 0 ? 8'h2C : (k == 1 ? 8'h3F : 8'h0C);
            wb(4'h4, k == 2 ? 32'h0 : 32'h1, 4'h1, 1'b1);
            wb(4'h0, {24'h0, c}, 4'h1, 1'b1);
            repeat (40) @(posedge ref_clk);
            h = 0;
            for (j = 0; j < 16; j++) begin
               @(posedge ref_clk);
               h = h + (pin_out === 1'b1);
            end
            chk(h, k == 0 ? 6 : (k == 1 ? 7 : 0));
            wb(4'h4, 32'h0, 4'h1, 1'b0);
            chk(rdat[17:8], k == 0 ? 6 : (k == 1 ? 7 : 0));
         end
         wb(4'h0, 32'h0, 4'h1, 1'b1);
         repeat (3) @(posedge ref_clk);
         #1 chk(pin_oe, 1'b0);
      end
   endtask
   initial begin
      {cyc, stb, we, match, adc_en, ext} = 6'h0;
      {adr, sel, dat} = 40'h0;
      repeat (4) @(posedge ref_clk);
      rst_n <= 1'b1;
      adc_en <= 1'b1;
      @(posedge ref_clk);
      t_regs;
      t_capture;
      t_compare;
      t_irq;
      t_pwm;
      wrap_up;
   end
endmodule
